// ==== hw/preload_pkg.sv ====
// constants and types shared by the configuration preload block
package preload_pkg;

   // ----------------------------------------------------------------
   // preload memory word addresses
   // ----------------------------------------------------------------
   localparam logic [7:0]  ADDR_SIGNATURE = 8'h00;
   localparam logic [7:0]  ADDR_CAPS      = 8'h06;
   localparam logic [7:0]  ADDR_FEATURES  = 8'h0c;
   localparam logic [7:0]  ADDR_MARGIN    = 8'h0e;
   localparam logic [7:0]  ADDR_NOMINAL   = 8'h10;
   // arbitrary value, not tied to any maker
   localparam logic [15:0] SIGNATURE_DEF  = 16'ha55a;

   localparam int NUM_PORTS = 6;
   localparam int NUM_STEPS = 5;

   // ----------------------------------------------------------------
   // word field positions
   // ----------------------------------------------------------------
   localparam int W06_VC       = 0;
   localparam int W06_L0S_LO   = 1;
   localparam int W06_L1_LO    = 4;
   localparam int W06_CLK_PM   = 7;
   localparam int W06_NO_EGR   = 8;
   localparam int W06_NO_TAG   = 9;
   localparam int W06_SF       = 10;
   localparam int W06_CT_LO    = 11;
   localparam int W06_ARB      = 13;
   localparam int W06_CRED     = 14;
   localparam int W06_NP_SF    = 15;
   localparam int W0C_MPS_LO   = 0;
   localparam int W0C_ASPM_LO  = 2;
   localparam int W0C_RBER     = 4;
   localparam int W0C_MSI_DIS  = 5;
   localparam int W0C_CPP_DIS  = 6;
   localparam int W0C_PM_DIS   = 7;
   localparam int W0C_PPNP     = 8;
   localparam int W0C_LBN      = 9;
   localparam int W0C_FREEZE   = 10;
   localparam int W0C_SOF      = 11;
   localparam int W0C_SURPRISE = 12;
   localparam int W0C_PMDATA   = 13;
   localparam int W0C_LTR      = 14;
   localparam int W0C_BND4K    = 15;
   localparam int W0E_LOW_LO   = 0;
   localparam int W0E_HIGH_LO  = 5;
   localparam int W0E_HALF_LO  = 10;
   localparam int W0E_OBFF     = 15;
   localparam int W10_NOM_LO   = 0;

   // ----------------------------------------------------------------
   // register map of the bus slave
   // ----------------------------------------------------------------
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_SIG    = 4'h8;
   localparam logic [3:0] REG_WORDS  = 4'hc;
   localparam int CTRL_RELOAD = 0;
   localparam int CTRL_HOLD   = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   // ----------------------------------------------------------------
   // per-port configuration fields
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       ext_vc_count;
      logic [2:0] l0s_exit_lat;
      logic [2:0] l1_exit_lat;
      logic       clock_pm_cap;
      logic       no_order_egress;
      logic       no_order_tag;
      logic       store_forward;
      logic [1:0] cut_through_thr;
      logic       arbiter_mode;
      logic       credit_update_mode;
      logic       np_store_forward_only;
      logic [1:0] max_payload;
      logic [1:0] aspm_support;
      logic       role_err_report;
      logic       msi_disable;
      logic       compl_parity_disable;
      logic       pm_cap_disable;
      logic       posted_pass_nonposted_enable;
      logic       link_bw_notify;
      logic       ordering_frozen;
      logic       tx_sof_latency;
      logic       surprise_down;
      logic       pm_data_sel_rw;
      logic       ltr_enable;
      logic       boundary_4k_check;
      logic [4:0] margin_drive_level_low_deemph;
      logic [4:0] margin_drive_level_high_deemph;
      logic [4:0] margin_drive_level_half_swing;
      logic       obff_enable;
      logic [4:0] nominal_drive_level_low_deemph;
   } port_cfg_t;

   localparam port_cfg_t PORT_CFG_RESET = '0;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_REQ,
      ST_WAIT,
      ST_APPLY,
      ST_DONE
   } load_state_t;

endpackage : preload_pkg

// ==== hw/config_preload.sv ====
// configuration preload engine with wishbone status port
// ------------------------------------------------------------------
// What this block does
// - word 06h bit 0 sets extended vc count of every port.
// - word 06h bits 3:1 and 6:4 set l0s and l1 exit latency.
// - word 06h bit 7 sets clock power-management capability, all ports.
// - port 0 only: word 06h bits 8,9,10 set ordering and store-forward.
// - port 0 only: bits 12:11 cut-through threshold; 13,14,15 mode bits.
// - word 0Ch bits 1:0 set max payload support, all ports.
// - word 0Ch bits 3:2 set aspm support level, all ports.
// - word 0Ch bit 4 sets role-based error reporting, all ports.
// - word 0Ch bit 5 disables msi capability, all ports.
// - word 0Ch bit 6 disables compliance pattern parity, all ports.
// - word 0Ch bit 7 disables power-management capability, all ports.
// - bit 8 lets posted packets pass non-posted, all ports.
// - bit 9 sets link bandwidth notification, ports 1 to 5 only.
// - bit 10 freezes packet ordering, all ports.
// - bit 11 selects tx sof latency mode; zero gives shorter latency.
// - bit 12 enables surprise link-down reporting, all ports.
// - bit 13 makes pm data select writable, all ports.
// - bit 14 enables latency tolerance reporting, all ports.
// - bit 15 enables 4 KB boundary check, all ports.
// - word 0Eh three 5-bit margin drive codes to every port.
// - word 0Eh bit 15 enables buffer flush and fill, all ports.
// - word 10h bits 4:0 set nominal drive level, all ports.
// ------------------------------------------------------------------
module config_preload #(
   parameter logic [15:0] SIGNATURE = preload_pkg::SIGNATURE_DEF
) (
   input  wire logic                                      clk_i,
   input  wire logic                                      rst_i,
   // preload memory word reader, same clock
   output logic                                           mem_rd_o,
   output logic [7:0]                                     mem_addr_o,
   input  wire logic [15:0]                               mem_data_i,
   input  wire logic                                      mem_ack_i,
   // configuration space
   output preload_pkg::port_cfg_t [preload_pkg::NUM_PORTS-1:0] port_cfg_o,
   output logic                                           link_enable_o,
   output logic                                           load_busy_o,
   // wishbone classic slave
   input  wire logic                                      wb_cyc_i,
   input  wire logic                                      wb_stb_i,
   input  wire logic                                      wb_we_i,
   input  wire logic [3:0]                                wb_adr_i,
   input  wire logic [3:0]                                wb_sel_i,
   input  wire logic [31:0]                               wb_dat_i,
   output logic [31:0]                                    wb_dat_o,
   output logic                                           wb_ack_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   preload_pkg::load_state_t                         state_r;
   preload_pkg::load_state_t                         state_nxt;
   logic [2:0]                                       step_r;
   logic [15:0]                                      sig_r;
   logic [15:0]                                      w06_r;
   logic [15:0]                                      w0c_r;
   logic [15:0]                                      w0e_r;
   logic [15:0]                                      w10_r;
   logic                                             sig_ok_r;
   logic                                             sig_bad_r;
   logic [1:0]                                       ctrl_r;
   logic                                             reload_r;
   preload_pkg::port_cfg_t [preload_pkg::NUM_PORTS-1:0] cfg_r;
   preload_pkg::port_cfg_t [preload_pkg::NUM_PORTS-1:0] cfg_loaded;

   // ----------------------------------------------------------------
   // word address sequence
   // ----------------------------------------------------------------
   logic [7:0] step_addr;
   assign step_addr = (step_r == 3'd0) ? preload_pkg::ADDR_SIGNATURE :
                      (step_r == 3'd1) ? preload_pkg::ADDR_CAPS :
                      (step_r == 3'd2) ? preload_pkg::ADDR_FEATURES :
                      (step_r == 3'd3) ? preload_pkg::ADDR_MARGIN :
                                         preload_pkg::ADDR_NOMINAL;

   wire last_step  = (step_r == 3'(preload_pkg::NUM_STEPS - 1));
   wire sig_match  = (mem_data_i == SIGNATURE);
   wire got_word   = (state_r == preload_pkg::ST_WAIT) && mem_ack_i;
   // a bad signature aborts at once; nothing of the image is trusted
   wire sig_fail   = got_word && (step_r == 3'd0) && !sig_match;

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         preload_pkg::ST_IDLE:  state_nxt = preload_pkg::ST_REQ;
         preload_pkg::ST_REQ:   state_nxt = preload_pkg::ST_WAIT;
         preload_pkg::ST_WAIT: begin
            if (sig_fail) begin
               state_nxt = preload_pkg::ST_DONE;
            end else if (got_word) begin
               state_nxt = last_step ? preload_pkg::ST_APPLY : preload_pkg::ST_REQ;
            end
         end
         preload_pkg::ST_APPLY: state_nxt = preload_pkg::ST_DONE;
         preload_pkg::ST_DONE: begin
            if (reload_r) begin
               state_nxt = preload_pkg::ST_IDLE;
            end
         end
         default:               state_nxt = preload_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r <= preload_pkg::ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || state_r == preload_pkg::ST_IDLE) begin
         step_r <= 3'd0;
      end else if (got_word) begin
         step_r <= step_r + 3'd1;
      end
   end

   // ----------------------------------------------------------------
   // word capture
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         sig_r <= 16'h0000;
         w06_r <= 16'h0000;
         w0c_r <= 16'h0000;
         w0e_r <= 16'h0000;
         w10_r <= 16'h0000;
      end else if (got_word) begin
         case (step_r)
            3'd0:    sig_r <= mem_data_i;
            3'd1:    w06_r <= mem_data_i;
            3'd2:    w0c_r <= mem_data_i;
            3'd3:    w0e_r <= mem_data_i;
            default: w10_r <= mem_data_i;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i || state_r == preload_pkg::ST_IDLE) begin
         sig_ok_r  <= 1'b0;
         sig_bad_r <= 1'b0;
      end else if (got_word && step_r == 3'd0) begin
         sig_ok_r  <= sig_match;
         sig_bad_r <= !sig_match;
      end
   end

   // ----------------------------------------------------------------
   // scatter words into per-port fields
   // ----------------------------------------------------------------
   always_comb begin
      for (int p = 0; p < preload_pkg::NUM_PORTS; p++) begin
         cfg_loaded[p] = preload_pkg::PORT_CFG_RESET;
         cfg_loaded[p].ext_vc_count = w06_r[preload_pkg::W06_VC];
         cfg_loaded[p].l0s_exit_lat = w06_r[preload_pkg::W06_L0S_LO +: 3];
         cfg_loaded[p].l1_exit_lat  = w06_r[preload_pkg::W06_L1_LO +: 3];
         cfg_loaded[p].clock_pm_cap = w06_r[preload_pkg::W06_CLK_PM];
         if (p == 0) begin
            cfg_loaded[p].no_order_egress       = w06_r[preload_pkg::W06_NO_EGR];
            cfg_loaded[p].no_order_tag          = w06_r[preload_pkg::W06_NO_TAG];
            cfg_loaded[p].store_forward         = w06_r[preload_pkg::W06_SF];
            cfg_loaded[p].cut_through_thr       = w06_r[preload_pkg::W06_CT_LO +: 2];
            cfg_loaded[p].arbiter_mode          = w06_r[preload_pkg::W06_ARB];
            cfg_loaded[p].credit_update_mode    = w06_r[preload_pkg::W06_CRED];
            cfg_loaded[p].np_store_forward_only = w06_r[preload_pkg::W06_NP_SF];
         end
         cfg_loaded[p].max_payload          = w0c_r[preload_pkg::W0C_MPS_LO +: 2];
         cfg_loaded[p].aspm_support         = w0c_r[preload_pkg::W0C_ASPM_LO +: 2];
         cfg_loaded[p].role_err_report      = w0c_r[preload_pkg::W0C_RBER];
         cfg_loaded[p].msi_disable          = w0c_r[preload_pkg::W0C_MSI_DIS];
         cfg_loaded[p].compl_parity_disable = w0c_r[preload_pkg::W0C_CPP_DIS];
         cfg_loaded[p].pm_cap_disable       = w0c_r[preload_pkg::W0C_PM_DIS];
         cfg_loaded[p].posted_pass_nonposted_enable = w0c_r[preload_pkg::W0C_PPNP];
         if (p != 0) begin
            cfg_loaded[p].link_bw_notify = w0c_r[preload_pkg::W0C_LBN];
         end
         cfg_loaded[p].ordering_frozen   = w0c_r[preload_pkg::W0C_FREEZE];
         cfg_loaded[p].tx_sof_latency    = w0c_r[preload_pkg::W0C_SOF];
         cfg_loaded[p].surprise_down     = w0c_r[preload_pkg::W0C_SURPRISE];
         cfg_loaded[p].pm_data_sel_rw    = w0c_r[preload_pkg::W0C_PMDATA];
         cfg_loaded[p].ltr_enable        = w0c_r[preload_pkg::W0C_LTR];
         cfg_loaded[p].boundary_4k_check = w0c_r[preload_pkg::W0C_BND4K];
         cfg_loaded[p].margin_drive_level_low_deemph  = w0e_r[preload_pkg::W0E_LOW_LO +: 5];
         cfg_loaded[p].margin_drive_level_high_deemph = w0e_r[preload_pkg::W0E_HIGH_LO +: 5];
         cfg_loaded[p].margin_drive_level_half_swing  = w0e_r[preload_pkg::W0E_HALF_LO +: 5];
         cfg_loaded[p].obff_enable = w0e_r[preload_pkg::W0E_OBFF];
         cfg_loaded[p].nominal_drive_level_low_deemph = w10_r[preload_pkg::W10_NOM_LO +: 5];
      end
   end

   // all ports take their copy in the same cycle, one cycle before link enable
   always_ff @(posedge clk_i) begin
      if (rst_i || state_r == preload_pkg::ST_IDLE) begin
         cfg_r <= '0;
      end else if (state_r == preload_pkg::ST_APPLY) begin
         cfg_r <= cfg_loaded;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         mem_rd_o      <= 1'b0;
         mem_addr_o    <= 8'h00;
         link_enable_o <= 1'b0;
         load_busy_o   <= 1'b1;
      end else begin
         if (state_r == preload_pkg::ST_REQ) begin
            mem_rd_o   <= 1'b1;
            mem_addr_o <= step_addr;
         end else if (got_word) begin
            mem_rd_o   <= 1'b0;
         end
         // link held off until done (port copies in place on a good signature) and while hold is set
         link_enable_o <= (state_r == preload_pkg::ST_DONE) && !reload_r
                          && !ctrl_r[preload_pkg::CTRL_HOLD];
         load_busy_o   <= (state_nxt != preload_pkg::ST_DONE);
      end
   end

   assign port_cfg_o = cfg_r;

   // ----------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------
   wire        wb_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   // a write lands on the edge at which the master sees ack, not before
   wire        wb_wr    = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0];
   wire        hit_ctrl = (wb_adr_i == preload_pkg::REG_CTRL);
   wire [31:0] rd_mux   =
      hit_ctrl                               ? {30'h0, ctrl_r} :
      (wb_adr_i == preload_pkg::REG_STATUS)  ? {28'h0, sig_bad_r, sig_ok_r,
                                                (state_r == preload_pkg::ST_DONE),
                                                load_busy_o} :
      (wb_adr_i == preload_pkg::REG_SIG)     ? {16'h0, sig_r} :
      (wb_adr_i == preload_pkg::REG_WORDS)   ? {w0c_r, w06_r} :
                                               32'h0000_0000;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= wb_req;
         wb_dat_o <= (wb_req && !wb_we_i) ? rd_mux : 32'h0000_0000;
      end
   end

   // reload request is remembered until the sequencer is back in idle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl_r   <= preload_pkg::CTRL_RESET;
         reload_r <= 1'b0;
      end else begin
         if (wb_wr && hit_ctrl) begin
            ctrl_r[preload_pkg::CTRL_HOLD] <= wb_dat_i[preload_pkg::CTRL_HOLD];
         end
         if (wb_wr && hit_ctrl && wb_dat_i[preload_pkg::CTRL_RELOAD]) begin
            reload_r <= 1'b1;
         end else if (state_r == preload_pkg::ST_IDLE) begin
            reload_r <= 1'b0;
         end
         ctrl_r[preload_pkg::CTRL_RELOAD] <= reload_r;
      end
   end

endmodule : config_preload

// ==== sim/preload_checker.sv ====
// assertions on the ports of the configuration preload block
module preload_checker #(
   parameter logic [15:0] SIGNATURE = preload_pkg::SIGNATURE_DEF
) (
   input wire logic                                             clk_i,
   input wire logic                                             rst_i,
   input wire logic                                             mem_rd_o,
   input wire logic [7:0]                                       mem_addr_o,
   input wire logic [15:0]                                      mem_data_i,
   input wire logic                                             mem_ack_i,
   input wire preload_pkg::port_cfg_t [preload_pkg::NUM_PORTS-1:0] port_cfg_o,
   input wire logic                                             link_enable_o,
   input wire logic                                             load_busy_o,
   input wire logic                                             wb_cyc_i,
   input wire logic                                             wb_stb_i,
   input wire logic                                             wb_we_i,
   input wire logic [3:0]                                       wb_adr_i,
   input wire logic [3:0]                                       wb_sel_i,
   input wire logic [31:0]                                      wb_dat_i,
   input wire logic [31:0]                                      wb_dat_o,
   input wire logic                                             wb_ack_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic ack_00, ack_06, ack_10;
   assign ack_00 = mem_rd_o && mem_ack_i && mem_addr_o == 8'h00;
   assign ack_06 = mem_rd_o && mem_ack_i && mem_addr_o == 8'h06;
   assign ack_10 = mem_rd_o && mem_ack_i && mem_addr_o == 8'h10;
   // ----------------------------------------------------------------
   // word reader and load sequence
   // ----------------------------------------------------------------
   a_reset_state: assert property (disable iff (1'b0) rst_i |=> load_busy_o && !mem_rd_o
      && !link_enable_o && port_cfg_o == '0) else $error("outputs not idle in reset");
   a_rd_holds: assert property (mem_rd_o && !mem_ack_i |=> mem_rd_o && $stable(mem_addr_o))
      else $error("word request dropped before answer");
   a_word_order: assert property (ack_06 |=> !mem_rd_o ##1 (mem_rd_o && mem_addr_o == 8'h0c))
      else $error("word after 06h is not 0Ch");
   a_load_finish: assert property (ack_10 |-> ##2 !load_busy_o)
      else $error("load not finished after last word");
   a_bad_sig: assert property (ack_00 && mem_data_i != SIGNATURE |=> !mem_rd_o [*4])
      else $error("reads continue after bad signature");
   a_link_idle: assert property (link_enable_o |-> !load_busy_o)
      else $error("link enabled while loading");
   // ----------------------------------------------------------------
   // per-port field placement
   // ----------------------------------------------------------------
   a_lbn_port0: assert property (port_cfg_o[0].link_bw_notify == 1'b0)
      else $error("bandwidth notify set on port 0");
   a_port0_only: assert property (port_cfg_o[1].store_forward == 1'b0
      && port_cfg_o[5].cut_through_thr == 2'h0) else $error("switch mode on downstream port");
   a_ports_agree: assert property (link_enable_o |-> port_cfg_o[5].max_payload
      == port_cfg_o[0].max_payload && port_cfg_o[3].nominal_drive_level_low_deemph
      == port_cfg_o[0].nominal_drive_level_low_deemph) else $error("ports disagree");
   // ----------------------------------------------------------------
   // register bus
   // ----------------------------------------------------------------
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("bus request not answered next cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
   a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data outside ack");
   c_good_load: cover property (ack_10);
   c_bad_sig: cover property (ack_00 && mem_data_i != SIGNATURE);
   c_bus_write: cover property (wb_ack_o && wb_we_i);
endmodule : preload_checker

bind config_preload preload_checker #(.SIGNATURE(SIGNATURE)) u_checker (.clk_i(clk_i),
   .rst_i(rst_i), .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i),
   .mem_ack_i(mem_ack_i), .port_cfg_o(port_cfg_o), .link_enable_o(link_enable_o),
   .load_busy_o(load_busy_o), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o));

// ==== sim/preload_mem_model.sv ====
// behavioural preload memory answering word reads after a random wait
module preload_mem_model (
   input  wire logic             clk_i,
   input  wire logic             rd_i,
   input  wire logic [7:0]       addr_i,
   input  wire logic [4:0][15:0] words_i,
   output logic [15:0]           data_o = 16'h0,
   output logic                  ack_o = 1'b0
);
   timeunit 1ns;
   timeprecision 1ps;
   int          gap = 0;
   logic [15:0] word;
   assign word = (addr_i == 8'h06) ? words_i[1] : (addr_i == 8'h0c) ? words_i[2] :
                 (addr_i == 8'h0e) ? words_i[3] : (addr_i == 8'h10) ? words_i[4] : words_i[0];
   always @(posedge clk_i) begin
      ack_o <= 1'b0;
      if (rd_i && !ack_o && gap == 0) begin
         ack_o  <= 1'b1;
         data_o <= word;
         gap    <= $urandom_range(4, 0);
      end else begin
         // data lines toggle outside the answer, so a stale word is not held steady
         data_o <= ~data_o;
         if (rd_i && !ack_o) gap <= gap - 1;
      end
   end
endmodule : preload_mem_model

// ==== sim/tb_top.sv ====
// self-checking bench for the configuration preload block
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic mem_rd_o, mem_ack_i, link_enable_o, load_busy_o, wb_ack_o;
   logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
   logic [7:0] mem_addr_o;
   logic [15:0] mem_data_i;
   logic [4:0][15:0] words;
   preload_pkg::port_cfg_t [preload_pkg::NUM_PORTS-1:0] port_cfg_o;
   int w[5];
   int errors = 0;
   int total_checks = 0;
   always #20 clk_i = ~clk_i;

   config_preload DUT (.clk_i(clk_i), .rst_i(rst_i), .mem_rd_o(mem_rd_o),
      .mem_addr_o(mem_addr_o), .mem_data_i(mem_data_i), .mem_ack_i(mem_ack_i),
      .port_cfg_o(port_cfg_o), .link_enable_o(link_enable_o), .load_busy_o(load_busy_o),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
      .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
   preload_mem_model u_mem (.clk_i(clk_i), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
      .words_i(words), .data_o(mem_data_i), .ack_o(mem_ack_i));
   // ----------------------------------------------------------------
   // model and compares
   // ----------------------------------------------------------------
   function automatic preload_pkg::port_cfg_t exp_cfg(input int p);
      logic [15:0] a, c, e, n;
      logic        s;
      a = 16'(w[1]);
      c = 16'(w[2]);
      e = 16'(w[3]);
      n = 16'(w[4]);
      s = (p == 0);
      if (w[0] != int'(preload_pkg::SIGNATURE_DEF)) return '0;
      return {a[0], a[3:1], a[6:4], a[7],
         {a[8], a[9], a[10], a[12:11], a[13], a[14], a[15]} & {8{s}},
         c[1:0], c[3:2], c[4], c[5], c[6], c[7],
         c[8], c[9] & ~s, c[10], c[11], c[12], c[13], c[14], c[15],
         e[4:0], e[9:5], e[14:10], e[15], n[4:0]};
   endfunction : exp_cfg
   task automatic chk_cfg(input int p, input preload_pkg::port_cfg_t exp);
      total_checks++;
      if (port_cfg_o[p] !== exp) begin
         errors++;
         $display("BAD port_cfg %0d exp %h got %h", p, exp, port_cfg_o[p]);
      end
   endtask : chk_cfg
   task automatic chk32(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s exp %h got %h", what, exp, got);
      end
   endtask : chk32
   // ----------------------------------------------------------------
   // bus and load helpers
   // ----------------------------------------------------------------
   task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [3:0] sel,
                          input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk_i);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= we;
      wb_adr_i <= adr;
      wb_sel_i <= sel;
      wb_dat_i <= wd;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 50);
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_dat_i <= $urandom;
      if (n >= 50) errors++;
   endtask : wb_xfer
   task automatic wait_flag(input logic lvl);
      int n;
      n = 0;
      while (load_busy_o !== lvl && n < 400) begin
         @(posedge clk_i);
         n++;
      end
      if (n >= 400) errors++;
   endtask : wait_flag
   task automatic test_done;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : test_done
   initial begin
      repeat (5000) @(posedge clk_i);
      errors++;
      test_done();
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(32'h3d2dd1f7));
      for (int k = 0; k < 4; k++) begin
         for (int i = 1; i < 5; i++) w[i] = $urandom_range(65535, 0);
         // third load carries a broken signature
         w[0] = (k == 2) ? (preload_pkg::SIGNATURE_DEF ^ $urandom_range(65535, 1))
                         : preload_pkg::SIGNATURE_DEF;
         for (int i = 0; i < 5; i++) words[i] <= 16'(w[i]);
         if (k == 0) begin
            repeat (3) @(posedge clk_i);
            rst_i <= 1'b0;
         end else begin
            wb_xfer(1'b1, preload_pkg::REG_CTRL, 4'h1, 32'h1);
            wait_flag(1'b1);
         end
         wait_flag(1'b0);
         repeat (2) @(posedge clk_i);
         for (int p = 0; p < preload_pkg::NUM_PORTS; p++) chk_cfg(p, exp_cfg(p));
         chk32("link", 32'h1, {31'h0, link_enable_o});
         wb_xfer(1'b0, preload_pkg::REG_STATUS, 4'hf, 32'h0);
         chk32("status", {28'h0, k == 2, k != 2, 2'b10}, rd);
         wb_xfer(1'b0, preload_pkg::REG_SIG, 4'hf, 32'h0);
         chk32("sig", 32'(w[0]), rd);
         wb_xfer(1'b0, preload_pkg::REG_WORDS, 4'hf, 32'h0);
         if (k != 2) chk32("words", {16'(w[2]), 16'(w[1])}, rd);
      end
      wb_xfer(1'b1, preload_pkg::REG_CTRL, 4'he, 32'h2);
      repeat (2) @(posedge clk_i);
      chk32("link sel", 32'h1, {31'h0, link_enable_o});
      wb_xfer(1'b1, preload_pkg::REG_CTRL, 4'h1, 32'h2);
      repeat (2) @(posedge clk_i);
      chk32("link hold", 32'h0, {31'h0, link_enable_o});
      wb_xfer(1'b0, preload_pkg::REG_CTRL, 4'hf, 32'h0);
      chk32("ctrl", 32'h2, rd);
      wb_xfer(1'b1, 4'h2, 4'hf, $urandom);
      wb_xfer(1'b0, 4'h2, 4'hf, 32'h0);
      chk32("unmapped", 32'h0, rd);
      test_done();
   end
endmodule : tb_top
